// ===== hdl/irq_status_pkg.sv
// Constants and types shared by the interrupt pending-status block
package irq_status_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;
	localparam int CRIT_N = 4;
	localparam int MAIN_N = 17;
	localparam int PER_N  = 22;
	localparam int EXT_N  = 4;

	localparam logic [ADDR_W-1:0] CRIT_MAP_ADDR  = 12'h528;
	localparam logic [ADDR_W-1:0] MAIN_MAP_ADDR  = 12'h52c;
	localparam logic [ADDR_W-1:0] PER_MAP_ADDR   = 12'h530;
	localparam logic [ADDR_W-1:0] ERR_FLAGS_ADDR = 12'h538;
	localparam logic [ADDR_W-1:0] EXT_CTRL_ADDR  = 12'h540;
	localparam logic [ADDR_W-1:0] MAIN_MASK_ADDR = 12'h544;
	localparam logic [ADDR_W-1:0] PER_MASK_ADDR  = 12'h548;

	// Bit n counted from the msb sits at lsb position 31-n
	localparam int CRIT_LSB0     = 27;
	localparam int MAIN_LSB0     = 16;
	localparam int PER_LSB0      = 21;
	localparam int ERR_RO_BIT    = 25;
	localparam int ERR_UNIMP_BIT = 24;
	localparam int EXT_MEE_BIT   = 0;
	localparam int EXT_PIN_LSB   = 1;

	localparam int CRIT_EXT_SRC      = 0;
	localparam int MAIN_SMI_SRC      = 0;
	localparam int MAIN_EXT_LSB      = 1;
	localparam int MAIN_LOW_BANK_SRC = 4;

	localparam logic [MAIN_N-1:0] MAIN_MASK_RST = 17'h1ffff;
	localparam logic [PER_N-1:0]  PER_MASK_RST  = 22'h3fffff;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic [EXT_N-1:0] pin_en;
		logic             master_external_enable;
	} ext_ctrl_t;

	localparam ext_ctrl_t EXT_CTRL_RST = '{pin_en: 4'h0, master_external_enable: 1'b0};

	typedef struct packed {
		logic smi;
		logic crit;
		logic core;
	} core_irq_t;

	typedef enum logic {RD_IDLE, RD_DATA} rd_state_t;
	typedef enum logic {WR_COLLECT, WR_RESP} wr_state_t;

endpackage : irq_status_pkg

// ===== hdl/pending_bank.sv
// One bank of level pending bits with its masked request
`timescale 1ns/1ps
module pending_bank #(
	parameter int WIDTH = 4
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic [WIDTH-1:0] src,
	input  wire logic [WIDTH-1:0] src_en,
	input  wire logic [WIDTH-1:0] mask,
	output logic      [WIDTH-1:0] pending,
	output logic                  request
);

	logic [WIDTH-1:0] pending_reg;
	logic [WIDTH-1:0] pending_next;

	// A disabled source is never seen; the mask never hides status
	always_comb
	begin
		pending_next = src & src_en;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pending_reg <= '0;
		else
			pending_reg <= pending_next;
	end

	assign pending = pending_reg;
	assign request = |(pending_reg & ~mask);

endmodule : pending_bank

// ===== hdl/sticky_flag.sv
// Sticky flag set by hardware, cleared by software
`timescale 1ns/1ps
module sticky_flag (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic set,
	input  wire logic clear,
	output logic      flag
);

	logic flag_reg;
	logic flag_next;

	// Set wins so an error in the clearing cycle is kept
	always_comb
	begin
		flag_next = set | (flag_reg & ~clear);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flag_reg <= 1'b0;
		else
			flag_reg <= flag_next;
	end

	assign flag = flag_reg;

endmodule : sticky_flag

// ===== hdl/irq_status.sv
// Interrupt pending-status maps, bus-error flags and AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// [R1] Critical map bits 4..7: pin 0, slice timer one, high bank, wake-up.
// [R2] No critical mask; master external enable off blocks pin 0 status.
// [R3] Pin 0 enable off: status still set, no critical core interrupt.
// [R4] Main map holds sources 0..16 at bits 15..31 while pending.
// [R5] Main sources: timer two, pins 1-3, low bank, RTC, GPIO, timers.
// [R6] Main mask blocks only the core interrupt, never the status bit; bit 0 here gates the management output instead.
// [R7] A source disabled in its own module is neither seen nor recorded.
// [R8] Peripheral map holds sources 0..21 at bits 10..31.
// [R9] Peripheral status is set whatever the peripheral mask holds.
// [R10] Write to a read-only register sets bit 6; write one clears.
// [R11] Access to an unimplemented address sets bit 7; write one clears.
// [R12] Main source 0 drives only the management output, fixed priority.
// [R13] Status maps are read-only; reserved bits read zero.
module irq_status
	import irq_status_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [STRB_W-1:0] wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [DATA_W-1:0] rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [CRIT_N-1:0] crit_src,
	input  wire logic [CRIT_N-1:0] crit_src_en,
	input  wire logic [MAIN_N-1:0] main_src,
	input  wire logic [MAIN_N-1:0] main_src_en,
	input  wire logic [PER_N-1:0]  per_src,
	input  wire logic [PER_N-1:0]  per_src_en,
	output core_irq_t              irq_out,
	output logic                   per_irq
);

	function automatic logic is_status(input logic [ADDR_W-1:0] a);
		if (a == CRIT_MAP_ADDR)
			return 1'b1;
		else if (a == MAIN_MAP_ADDR)
			return 1'b1;
		else if (a == PER_MAP_ADDR)
			return 1'b1;
		else
			return 1'b0;
	endfunction : is_status

	function automatic logic is_rw(input logic [ADDR_W-1:0] a);
		if (a == ERR_FLAGS_ADDR)
			return 1'b1;
		else if (a == EXT_CTRL_ADDR)
			return 1'b1;
		else if (a == MAIN_MASK_ADDR)
			return 1'b1;
		else if (a == PER_MASK_ADDR)
			return 1'b1;
		else
			return 1'b0;
	endfunction : is_rw

	function automatic logic [DATA_W-1:0] lane_mask(
		input logic [STRB_W-1:0] strb);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < STRB_W; i++)
			m[i*8 +: 8] = {8{strb[i]}};
		return m;
	endfunction : lane_mask

	wr_state_t         wr_state_reg, wr_state_next;
	logic              aw_held_reg, aw_held_next;
	logic              w_held_reg, w_held_next;
	logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
	logic [DATA_W-1:0] wr_data_reg, wr_data_next;
	logic [STRB_W-1:0] wr_strb_reg, wr_strb_next;
	logic [1:0]        bresp_reg, bresp_next;
	ext_ctrl_t         ext_ctrl_reg, ext_ctrl_next;
	logic [MAIN_N-1:0] main_mask_reg, main_mask_next;
	logic [PER_N-1:0]  per_mask_reg, per_mask_next;
	rd_state_t         rd_state_reg, rd_state_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [1:0]        rresp_reg, rresp_next;

	logic [CRIT_N-1:0] crit_pending, crit_en_eff, crit_mask_eff;
	logic [MAIN_N-1:0] main_pending, main_en_eff, main_mask_eff;
	logic [PER_N-1:0]  per_pending;
	logic              crit_req, main_req;
	logic [DATA_W-1:0] crit_map, main_map, per_map, err_map;
	logic [DATA_W-1:0] wr_bits, wr_lanes;
	logic              err_ro, err_unimp;
	logic              ro_set, unimp_wr_set, unimp_rd_set;
	logic              ro_clear, unimp_clear;

	// Gating of external pins and effective masks
	always_comb
	begin
		crit_en_eff = crit_src_en;
		crit_en_eff[CRIT_EXT_SRC] = crit_src_en[CRIT_EXT_SRC] &
			ext_ctrl_reg.master_external_enable; // [R2]
		crit_mask_eff = '0; // [R2]
		crit_mask_eff[CRIT_EXT_SRC] =
			~ext_ctrl_reg.pin_en[CRIT_EXT_SRC]; // [R3]
		main_en_eff = main_src_en; // [R7]
		main_mask_eff = main_mask_reg; // [R6]
		for (int i = 1; i < EXT_N; i++)
		begin
			main_en_eff[MAIN_EXT_LSB+i-1] = main_src_en[MAIN_EXT_LSB+i-1] &
				ext_ctrl_reg.master_external_enable; // [R5]
			main_mask_eff[MAIN_EXT_LSB+i-1] =
				main_mask_reg[MAIN_EXT_LSB+i-1] | ~ext_ctrl_reg.pin_en[i];
		end
		// Timer two never reaches the normal core line
		main_mask_eff[MAIN_SMI_SRC] = 1'b1; // [R12]
	end

	pending_bank #(.WIDTH(CRIT_N)) crit_bank (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src     (crit_src),
		.src_en  (crit_en_eff),
		.mask    (crit_mask_eff),
		.pending (crit_pending),
		.request (crit_req)
	);

	pending_bank #(.WIDTH(MAIN_N)) main_bank (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src     (main_src),
		.src_en  (main_en_eff),
		.mask    (main_mask_eff),
		.pending (main_pending),
		.request (main_req)
	);

	pending_bank #(.WIDTH(PER_N)) per_bank (
		.aclk    (aclk),
		.aresetn (aresetn),
		.src     (per_src),
		.src_en  (per_src_en), // [R9]
		.mask    (per_mask_reg),
		.pending (per_pending),
		.request (per_irq)
	);

	sticky_flag ro_flag (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set     (ro_set),
		.clear   (ro_clear),
		.flag    (err_ro)
	);

	sticky_flag unimp_flag (
		.aclk    (aclk),
		.aresetn (aresetn),
		.set     (unimp_wr_set | unimp_rd_set),
		.clear   (unimp_clear),
		.flag    (err_unimp)
	);

	assign irq_out.crit = crit_req; // [R3]
	assign irq_out.core = main_req;
	assign irq_out.smi  = main_pending[MAIN_SMI_SRC] &
		~main_mask_reg[MAIN_SMI_SRC]; // [R12]

	// Bit-reversed placement of the status maps
	always_comb
	begin
		crit_map = '0;
		main_map = '0;
		per_map  = '0;
		err_map  = '0;
		for (int i = 0; i < CRIT_N; i++)
			crit_map[CRIT_LSB0-i] = crit_pending[i]; // [R1]
		for (int i = 0; i < MAIN_N; i++)
			main_map[MAIN_LSB0-i] = main_pending[i]; // [R4]
		for (int i = 0; i < PER_N; i++)
			per_map[PER_LSB0-i] = per_pending[i]; // [R8]
		err_map[ERR_RO_BIT]    = err_ro;
		err_map[ERR_UNIMP_BIT] = err_unimp;
	end

	assign awready = (wr_state_reg == WR_COLLECT) && !aw_held_reg;
	assign wready  = (wr_state_reg == WR_COLLECT) && !w_held_reg;
	assign bvalid  = (wr_state_reg == WR_RESP);
	assign bresp   = bresp_reg;
	assign wr_lanes = lane_mask(wr_strb_reg);
	assign wr_bits  = wr_data_reg & wr_lanes;

	// Address and data are caught in either order, then executed
	always_comb
	begin
		wr_state_next  = wr_state_reg;
		aw_held_next   = aw_held_reg;
		w_held_next    = w_held_reg;
		wr_addr_next   = wr_addr_reg;
		wr_data_next   = wr_data_reg;
		wr_strb_next   = wr_strb_reg;
		bresp_next     = bresp_reg;
		ext_ctrl_next  = ext_ctrl_reg;
		main_mask_next = main_mask_reg;
		per_mask_next  = per_mask_reg;
		ro_set         = 1'b0;
		unimp_wr_set   = 1'b0;
		ro_clear       = 1'b0;
		unimp_clear    = 1'b0;
		if (awvalid && awready)
		begin
			aw_held_next = 1'b1;
			wr_addr_next = awaddr;
		end
		if (wvalid && wready)
		begin
			w_held_next  = 1'b1;
			wr_data_next = wdata;
			wr_strb_next = wstrb;
		end
		case (wr_state_reg)
			WR_COLLECT:
			begin
				if (aw_held_reg && w_held_reg)
				begin
					aw_held_next  = 1'b0;
					w_held_next   = 1'b0;
					wr_state_next = WR_RESP;
					bresp_next    = RESP_OKAY;
					if (is_status(wr_addr_reg))
					begin
						ro_set     = 1'b1; // [R10]
						bresp_next = RESP_SLVERR; // [R13]
					end
					else if (wr_addr_reg == ERR_FLAGS_ADDR)
					begin
						ro_clear    = wr_bits[ERR_RO_BIT]; // [R10]
						unimp_clear = wr_bits[ERR_UNIMP_BIT]; // [R11]
					end
					else if (wr_addr_reg == EXT_CTRL_ADDR)
					begin
						if (wr_strb_reg[0])
						begin
							ext_ctrl_next.master_external_enable =
								wr_data_reg[EXT_MEE_BIT];
							ext_ctrl_next.pin_en =
								wr_data_reg[EXT_PIN_LSB +: EXT_N];
						end
					end
					else if (wr_addr_reg == MAIN_MASK_ADDR)
						main_mask_next = wr_bits[MAIN_N-1:0] |
							(main_mask_reg &
							~wr_lanes[MAIN_N-1:0]);
					else if (wr_addr_reg == PER_MASK_ADDR)
						per_mask_next = wr_bits[PER_N-1:0] |
							(per_mask_reg &
							~wr_lanes[PER_N-1:0]);
					else
					begin
						unimp_wr_set = 1'b1; // [R11]
						bresp_next   = RESP_DECERR;
					end
				end
			end
			WR_RESP:
			begin
				if (bready)
					wr_state_next = WR_COLLECT;
			end
			default:
				wr_state_next = WR_COLLECT;
		endcase
	end

	assign arready = (rd_state_reg == RD_IDLE);
	assign rvalid  = (rd_state_reg == RD_DATA);
	assign rdata   = rdata_reg;
	assign rresp   = rresp_reg;

	// Read data is latched at the address edge, so it is a snapshot
	always_comb
	begin
		rd_state_next = rd_state_reg;
		rdata_next    = rdata_reg;
		rresp_next    = rresp_reg;
		unimp_rd_set  = 1'b0;
		case (rd_state_reg)
			RD_IDLE:
			begin
				if (arvalid)
				begin
					rd_state_next = RD_DATA;
					rresp_next    = RESP_OKAY;
					if (araddr == CRIT_MAP_ADDR)
						rdata_next = crit_map;
					else if (araddr == MAIN_MAP_ADDR)
						rdata_next = main_map;
					else if (araddr == PER_MAP_ADDR)
						rdata_next = per_map;
					else if (araddr == ERR_FLAGS_ADDR)
						rdata_next = err_map;
					else if (araddr == EXT_CTRL_ADDR)
						rdata_next = DATA_W'(ext_ctrl_reg);
					else if (araddr == MAIN_MASK_ADDR)
						rdata_next = DATA_W'(main_mask_reg);
					else if (araddr == PER_MASK_ADDR)
						rdata_next = DATA_W'(per_mask_reg);
					else
					begin
						rdata_next   = '0;
						rresp_next   = RESP_DECERR;
						unimp_rd_set = 1'b1; // [R11]
					end
				end
			end
			RD_DATA:
			begin
				if (rready)
					rd_state_next = RD_IDLE;
			end
			default:
				rd_state_next = RD_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_state_reg  <= WR_COLLECT;
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			wr_addr_reg   <= '0;
			wr_data_reg   <= '0;
			wr_strb_reg   <= '0;
			bresp_reg     <= RESP_OKAY;
			ext_ctrl_reg  <= EXT_CTRL_RST;
			main_mask_reg <= MAIN_MASK_RST;
			per_mask_reg  <= PER_MASK_RST;
			rd_state_reg  <= RD_IDLE;
			rdata_reg     <= '0;
			rresp_reg     <= RESP_OKAY;
		end
		else
		begin
			wr_state_reg  <= wr_state_next;
			aw_held_reg   <= aw_held_next;
			w_held_reg    <= w_held_next;
			wr_addr_reg   <= wr_addr_next;
			wr_data_reg   <= wr_data_next;
			wr_strb_reg   <= wr_strb_next;
			bresp_reg     <= bresp_next;
			ext_ctrl_reg  <= ext_ctrl_next;
			main_mask_reg <= main_mask_next;
			per_mask_reg  <= per_mask_next;
			rd_state_reg  <= rd_state_next;
			rdata_reg     <= rdata_next;
			rresp_reg     <= rresp_next;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_crit_map_order: assert property ( // [R1]
		arvalid && arready && araddr == CRIT_MAP_ADDR |=>
		rdata[CRIT_LSB0] == $past(crit_pending[0]) &&
		rdata[CRIT_LSB0-CRIT_N+1] == $past(crit_pending[CRIT_N-1]))
		else $error("critical map bit order wrong");

	a_mee_blocks_pin: assert property ( // [R2]
		!ext_ctrl_reg.master_external_enable |=> !crit_pending[CRIT_EXT_SRC])
		else $error("pin 0 recorded while master enable off");

	a_pin_en_quiet: assert property ( // [R3]
		ext_ctrl_reg.master_external_enable && !ext_ctrl_reg.pin_en[CRIT_EXT_SRC] &&
		crit_src[CRIT_EXT_SRC] && crit_src_en[CRIT_EXT_SRC] &&
		crit_src[CRIT_N-1:1] == '0 |=>
		crit_pending[CRIT_EXT_SRC] &&
		(ext_ctrl_reg.pin_en[CRIT_EXT_SRC] || !irq_out.crit))
		else $error("pin enable off must keep status, not interrupt");

	a_main_map_pos: assert property ( // [R4]
		arvalid && arready && araddr == MAIN_MAP_ADDR |=>
		rdata[MAIN_LSB0] == $past(main_pending[0]) &&
		rdata[0] == $past(main_pending[MAIN_N-1]) &&
		rdata[DATA_W-1:MAIN_LSB0+1] == '0)
		else $error("main map placement wrong");

	a_low_bank_core: assert property ( // [R5]
		main_pending[MAIN_LOW_BANK_SRC] &&
		!main_mask_reg[MAIN_LOW_BANK_SRC] |-> irq_out.core)
		else $error("low bank summary did not reach core");

	a_mask_keeps_bit: assert property ( // [R6]
		aresetn && main_src[MAIN_N-1] && main_src_en[MAIN_N-1] &&
		main_mask_reg[MAIN_N-1] |=> main_pending[MAIN_N-1])
		else $error("masked main source lost its status");

	a_module_en_gate: assert property ( // [R7]
		1'b1 |=> (main_pending & ~$past(main_src_en)) == '0)
		else $error("disabled main source recorded");

	a_per_map_pos: assert property ( // [R8]
		arvalid && arready && araddr == PER_MAP_ADDR |=>
		rdata[PER_LSB0] == $past(per_pending[0]) &&
		rdata[0] == $past(per_pending[PER_N-1]))
		else $error("peripheral map placement wrong");

	a_per_no_mask: assert property ( // [R9]
		aresetn |=> per_pending == $past(per_src & per_src_en))
		else $error("peripheral status depends on mask");

	a_ro_write_flag: assert property ( // [R10]
		wr_state_reg == WR_COLLECT && aw_held_reg && w_held_reg &&
		is_status(wr_addr_reg) |=> err_ro && bvalid &&
		bresp == RESP_SLVERR)
		else $error("read-only write not flagged");

	a_unimp_flag: assert property ( // [R11]
		arvalid && arready && !is_status(araddr) && !is_rw(araddr)
		|=> err_unimp && rvalid && rresp == RESP_DECERR)
		else $error("unmapped read not flagged");

	a_smi_only: assert property ( // [R12]
		main_pending[MAIN_N-1:1] == '0 |-> !irq_out.core)
		else $error("timer two reached the core line");

endmodule : irq_status

// ===== verif/irq_source_model.sv
// Model of the peripheral modules and pins that feed the status block
`timescale 1ns/1ps
module irq_source_model
	import irq_status_pkg::*;
(
	input  wire logic              aclk,
	output logic      [CRIT_N-1:0] crit_src,
	output logic      [CRIT_N-1:0] crit_src_en,
	output logic      [MAIN_N-1:0] main_src,
	output logic      [MAIN_N-1:0] main_src_en,
	output logic      [PER_N-1:0]  per_src,
	output logic      [PER_N-1:0]  per_src_en
);
	initial
	begin
		{crit_src, crit_src_en, main_src, main_src_en} = '0;
		{per_src, per_src_en} = '0;
	end

	// Requests are levels; each module's enable is driven ungated beside its request
	task automatic apply(input logic [CRIT_N-1:0] cs,
		input logic [CRIT_N-1:0] ce,
		input logic [MAIN_N-1:0] ms, input logic [MAIN_N-1:0] me,
		input logic [PER_N-1:0] ps, input logic [PER_N-1:0] pe);
		@(posedge aclk);
		crit_src    <= cs;
		crit_src_en <= ce;
		main_src    <= ms;
		main_src_en <= me;
		per_src     <= ps;
		per_src_en  <= pe;
	endtask : apply
endmodule : irq_source_model

// ===== verif/irq_status_tb.sv
// Self-checking bench for the interrupt pending-status block
`timescale 1ns/1ps
module irq_status_tb
	import irq_status_pkg::*;
;
	localparam logic [ADDR_W-1:0] UNMAPPED_ADDR = 12'h600;

	typedef struct packed {
		logic [4:0]  ext;
		logic [3:0]  cs, ce;
		logic [16:0] ms, me;
		logic [21:0] ps, pe;
		logic [31:0] xc, xm, xp;
		logic [2:0]  xi;
	} row_t;

	logic              aclk, aresetn;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic              awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [DATA_W-1:0] wdata, rdata;
	logic [1:0]        bresp, rresp;
	logic [CRIT_N-1:0] crit_src, crit_src_en;
	logic [MAIN_N-1:0] main_src, main_src_en;
	logic [PER_N-1:0]  per_src, per_src_en;
	core_irq_t         irq_out;
	logic              per_irq;
	int                num_errors, n_compared;
	row_t              rows [5];

	irq_status dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .crit_src(crit_src),
		.crit_src_en(crit_src_en), .main_src(main_src),
		.main_src_en(main_src_en), .per_src(per_src), .per_src_en(per_src_en),
		.irq_out(irq_out), .per_irq(per_irq));

	irq_source_model src_model (.aclk(aclk), .crit_src(crit_src),
		.crit_src_en(crit_src_en), .main_src(main_src),
		.main_src_en(main_src_en), .per_src(per_src), .per_src_en(per_src_en));

	initial
	begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic end_of_test;
		if (num_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check

	// Address and data are offered together; each drops once taken
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [1:0] xr);
		bit done;
		done = 0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int i = 0; i < 50 && !done; i++)
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1 && bready)
			begin
				check({30'h0, bresp}, {30'h0, xr}, "write response");
				bready <= 1'b0;
				done = 1;
			end
		end
		if (!done)
		begin
			num_errors++;
			$display("mismatch at %0t: write never answered", $time);
			end_of_test();
		end
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] xd,
		input logic [1:0] xr);
		bit done;
		done = 0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (int i = 0; i < 50 && !done; i++)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1 && rready)
			begin
				check(rdata, xd, "read data");
				check({30'h0, rresp}, {30'h0, xr}, "read response");
				rready <= 1'b0;
				done = 1;
			end
		end
		if (!done)
		begin
			num_errors++;
			$display("mismatch at %0t: read never answered", $time);
			end_of_test();
		end
	endtask : rd

	// Pending bits trail the sources by one cycle, so let two edges pass
	task automatic irq_is(input logic [2:0] x, input logic xp);
		repeat (2) @(posedge aclk);
		check({29'h0, irq_out}, {29'h0, x}, "core interrupts");
		check({31'h0, per_irq}, {31'h0, xp}, "peripheral interrupt");
	endtask : irq_is

	initial
	begin
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		num_errors = 0;
		n_compared = 0;
		aresetn = 1'b0;
		rows[0] = '{5'h01, 4'hf, 4'hf, 17'h1ffff, 17'h1ffff, 22'h3fffff,
			22'h3fffff, 32'h0f000000, 32'h0001ffff, 32'h003fffff, 3'b010};
		rows[1] = '{5'h00, 4'hf, 4'hf, 17'h1ffff, 17'h1ffff, 22'h3fffff,
			22'h3fffff, 32'h07000000, 32'h00011fff, 32'h003fffff, 3'b010};
		rows[2] = '{5'h01, 4'h1, 4'he, 17'h00001, 17'h00001, 22'h000001,
			22'h000001, 32'h0, 32'h00010000, 32'h00200000, 3'b000};
		rows[3] = '{5'h1f, 4'h8, 4'hf, 17'h10000, 17'h1ffff, 22'h200000,
			22'h3fffff, 32'h01000000, 32'h00000001, 32'h00000001, 3'b010};
		rows[4] = '{5'h1f, 4'h0, 4'h0, 17'h1ffff, 17'h0, 22'h3fffff,
			22'h0, 32'h0, 32'h0, 32'h0, 3'b000};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CRIT_MAP_ADDR, 32'h0, RESP_OKAY);
		rd(MAIN_MAP_ADDR, 32'h0, RESP_OKAY);
		rd(PER_MAP_ADDR, 32'h0, RESP_OKAY);
		rd(ERR_FLAGS_ADDR, 32'h0, RESP_OKAY);
		rd(MAIN_MASK_ADDR, 32'h0001ffff, RESP_OKAY);
		rd(PER_MASK_ADDR, 32'h003fffff, RESP_OKAY);
		foreach (rows[i])
		begin
			wr(EXT_CTRL_ADDR, {27'h0, rows[i].ext}, RESP_OKAY);
			src_model.apply(rows[i].cs, rows[i].ce, rows[i].ms, rows[i].me,
				rows[i].ps, rows[i].pe);
			irq_is(rows[i].xi, 1'b0);
			rd(CRIT_MAP_ADDR, rows[i].xc, RESP_OKAY);
			rd(MAIN_MAP_ADDR, rows[i].xm, RESP_OKAY);
			rd(PER_MAP_ADDR, rows[i].xp, RESP_OKAY);
		end
		// Pin 0 recorded but kept from the core until its pin enable is set
		wr(EXT_CTRL_ADDR, 32'h1, RESP_OKAY);
		src_model.apply(4'h1, 4'hf, '0, '0, '0, '0);
		irq_is(3'b000, 1'b0);
		rd(CRIT_MAP_ADDR, 32'h08000000, RESP_OKAY);
		wr(EXT_CTRL_ADDR, 32'h3, RESP_OKAY);
		irq_is(3'b010, 1'b0);
		// Timer two reaches only the management output
		wr(MAIN_MASK_ADDR, 32'h0, RESP_OKAY);
		src_model.apply('0, '0, 17'h00001, 17'h1ffff, '0, '0);
		irq_is(3'b100, 1'b0);
		// Pin 1 is recorded but needs its pin enable to reach the core
		src_model.apply('0, '0, 17'h00002, 17'h1ffff, '0, '0);
		irq_is(3'b000, 1'b0);
		rd(MAIN_MAP_ADDR, 32'h00008000, RESP_OKAY);
		wr(EXT_CTRL_ADDR, 32'h5, RESP_OKAY);
		irq_is(3'b001, 1'b0);
		src_model.apply('0, '0, 17'h00020, 17'h1ffff, '0, '0);
		irq_is(3'b001, 1'b0);
		wr(MAIN_MASK_ADDR, 32'h20, RESP_OKAY);
		irq_is(3'b000, 1'b0);
		rd(MAIN_MAP_ADDR, 32'h00000800, RESP_OKAY);
		src_model.apply('0, '0, '0, '0, 22'h2, 22'h2);
		irq_is(3'b000, 1'b0);
		rd(PER_MAP_ADDR, 32'h00100000, RESP_OKAY);
		wr(PER_MASK_ADDR, 32'h0, RESP_OKAY);
		irq_is(3'b000, 1'b1);
		// Illegal accesses raise sticky flags; write one clears each alone
		wr(MAIN_MAP_ADDR, 32'hffffffff, RESP_SLVERR);
		rd(MAIN_MAP_ADDR, 32'h0, RESP_OKAY);
		rd(ERR_FLAGS_ADDR, 32'h02000000, RESP_OKAY);
		rd(UNMAPPED_ADDR, 32'h0, RESP_DECERR);
		rd(ERR_FLAGS_ADDR, 32'h03000000, RESP_OKAY);
		wr(ERR_FLAGS_ADDR, 32'h02000000, RESP_OKAY);
		rd(ERR_FLAGS_ADDR, 32'h01000000, RESP_OKAY);
		wr(ERR_FLAGS_ADDR, 32'h01000000, RESP_OKAY);
		rd(ERR_FLAGS_ADDR, 32'h0, RESP_OKAY);
		wr(UNMAPPED_ADDR, 32'h1, RESP_DECERR);
		rd(ERR_FLAGS_ADDR, 32'h01000000, RESP_OKAY);
		// Mid-run reset with a source still active clears flags and pin enables, sets the peripheral mask
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ERR_FLAGS_ADDR, 32'h0, RESP_OKAY);
		rd(EXT_CTRL_ADDR, 32'h0, RESP_OKAY);
		rd(PER_MASK_ADDR, 32'h003fffff, RESP_OKAY);
		irq_is(3'b000, 1'b0);
		rd(PER_MAP_ADDR, 32'h00100000, RESP_OKAY);
		end_of_test();
	end
endmodule : irq_status_tb
